/* File: src/sdadr_regs.svh */
/*
  register offsets, field positions, reset values and timing counts of the
  sdram array decode / refresh block. definitions only; included by bare name.
*/
`ifndef SDADR_REGS_SVH
`define SDADR_REGS_SVH

`define SDADR_TIMING_OFS   12'h_0100
`define SDADR_ARRAY0_OFS   12'h_0110
`define SDADR_ARRAY1_OFS   12'h_0114
`define SDADR_ARRAY2_OFS   12'h_0118
`define SDADR_ARRAY3_OFS   12'h_011C
`define SDADR_STATUS_OFS   12'h_0104

`define SDADR_PAR_EN_BIT   12
`define SDADR_PAR_CPU_BIT  13
`define SDADR_REF_LSB      16
`define SDADR_REF_MSB      24
`define SDADR_TIMING_RST   32'h_0000_0000
`define SDADR_TIMING_WMASK 32'h_01FF_3000

`define SDADR_SIZE_LSB     0
`define SDADR_SIZE_MSB     2
`define SDADR_MUX_LSB      4
`define SDADR_MUX_MSB      6
`define SDADR_BASE_LSB     20
`define SDADR_BASE_MSB     27
`define SDADR_ARRAY_RST    32'h_0000_0000
`define SDADR_ARRAY_WMASK  32'h_0FF0_0077

`define SDADR_PRESCALE     32

`endif

/* File: src/sdadr_pkg.sv */
/*
  types of the sdram array decode / refresh block.
  assumes the _regs header supplies numeric constants.
*/
package sdadr_pkg;

  // one decoded processor access towards the arrays
  typedef struct packed {
    logic       hit;
    logic [1:0] array_sel;
    logic [2:0] mux_mode;
  } sdadr_decode_t;

  // parity pin group: value and output enable
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } sdadr_par_pins_t;

  // refresh request state, gray coded along idle -> pending
  typedef enum logic [1:0] {
    SDADR_REF_IDLE    = 2'b00,
    SDADR_REF_PENDING = 2'b01,
    SDADR_REF_ISSUE   = 2'b11
  } sdadr_ref_state_t;

endpackage : sdadr_pkg

/* File: src/sdadr_match.sv */
/*
  one array's address compare against base and size.
  assumes a stable configuration word and a 28-bit byte address.
*/
`timescale 1ns/1ps
`include "sdadr_regs.svh"
module sdadr_match
  import sdadr_pkg::*;
(
  // configuration and address
  input  wire logic [31:0] cfg_i,
  input  wire logic [27:0] addr_i,
  // result
  output logic             hit_o
);

  logic [2:0] size;
  logic [7:0] mask;

  // size expands into a mask over bits 27:20; 000 disables the array
  always_comb
  begin
    size = cfg_i[`SDADR_SIZE_MSB:`SDADR_SIZE_LSB];
    mask = 8'h_FF << (size - 3'd1);
    hit_o = (size != 3'd0) &&
            (((addr_i[27:20] ^ cfg_i[`SDADR_BASE_MSB:`SDADR_BASE_LSB]) & mask) == 8'h_00);
  end

endmodule : sdadr_match

/* File: src/sdadr_top.sv */
/*
  sdram array decode, auto-refresh timer and parity control, as a classic
  wishbone slave. assumes one 100 MHz clock, synchronous active-high reset,
  and that software keeps arrays aligned and non-overlapping.
*/
// Functional notes
// - control bit 12 enables sdram parity; cleared at reset.
// - parity off: parity pins undriven, read parity not checked.
// - parity on: parity pins driven, read parity checked.
// - reset-cleared bit selects processor-supplied parity on writes.
// - refresh interval counted in clocks prescaled by 32; resets zero.
// - interval zero means no new automatic refresh; one already pending still issues.
// - refresh issued at the next bus arbitration point after expiry.
// - refresh timer reloads on expiry without waiting for the refresh.
// - four array registers set base, size and multiplexing.
// - size 000 disables, 001..111 select 1MB up to 64MB.
// - address bits 27:20 compared with base under the size mask.
// - bits 6:4 select row/column multiplex and bank count.
// - accesses hitting no array raise no error.
// - missed accesses may give undefined read data, dropped writes.
`timescale 1ns/1ps
`include "sdadr_regs.svh"
module sdadr_top
  import sdadr_pkg::*;
#(
  parameter int NUM_ARRAYS = 4,
  parameter int PRESCALE   = `SDADR_PRESCALE
)
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // processor side access
  input  wire logic        mem_req_i,
  input  wire logic        mem_write_i,
  input  wire logic [27:0] mem_addr_i,
  input  wire logic        arb_point_i,
  input  wire logic [3:0]  cpu_parity_i,
  input  wire logic [31:0] mem_wdata_i,
  // sdram side
  output logic             ref_cmd_o,
  output sdadr_decode_t    decode_o,
  output sdadr_par_pins_t  par_pins_o,
  input  wire logic [3:0]  par_in_i,
  input  wire logic [31:0] mem_rdata_i,
  input  wire logic        rd_valid_i,
  output logic             par_err_o
);

  // ---------------------------------------------------------------
  // register state
  logic [31:0] timing_r, timing_nxt;
  logic [31:0] arr_r   [NUM_ARRAYS];
  logic [31:0] arr_nxt [NUM_ARRAYS];
  logic [31:0] dat_r, dat_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] bmask;
  logic        wr_go;
  // read back through the status word, so declared ahead of the bus decode
  logic          par_err_r;
  logic          ref_pend_r;
  sdadr_decode_t decode_r;

  // byte lanes become a bit mask for writes
  always_comb
  begin
    bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  end

  assign wr_go = cyc_i && stb_i && we_i && !ack_r;

  // bus decode and register writes; ack one cycle after the request
  always_comb
  begin
    timing_nxt = timing_r;
    dat_nxt    = 32'h_0000_0000;
    ack_nxt    = cyc_i && stb_i && !ack_r;
    for (int i = 0; i < NUM_ARRAYS; i++)
    begin
      arr_nxt[i] = arr_r[i];
    end
    if (adr_i == `SDADR_TIMING_OFS)
    begin
      dat_nxt = timing_r;
      if (wr_go)
      begin
        timing_nxt = (timing_r & ~(bmask & `SDADR_TIMING_WMASK)) |
                     (dat_i & bmask & `SDADR_TIMING_WMASK);
      end
    end
    else if (adr_i == `SDADR_STATUS_OFS)
    begin
      dat_nxt = {29'h_0000_0000, par_err_r, ref_pend_r, decode_r.hit};
    end
    else if (adr_i >= `SDADR_ARRAY0_OFS && adr_i <= `SDADR_ARRAY3_OFS && adr_i[1:0] == 2'b00)
    begin
      dat_nxt = arr_r[adr_i[3:2]];
      if (wr_go)
      begin
        arr_nxt[adr_i[3:2]] = (arr_r[adr_i[3:2]] & ~(bmask & `SDADR_ARRAY_WMASK)) |
                              (dat_i & bmask & `SDADR_ARRAY_WMASK);
      end
    end
    // unmapped addresses still ack and read zero
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timing_r <= `SDADR_TIMING_RST;
      dat_r    <= 32'h_0000_0000;
      ack_r    <= 1'b0;
      for (int i = 0; i < NUM_ARRAYS; i++)
      begin
        arr_r[i] <= `SDADR_ARRAY_RST;
      end
    end
    else if (ce_i)
    begin
      timing_r <= timing_nxt;
      dat_r    <= dat_nxt;
      ack_r    <= ack_nxt;
      arr_r    <= arr_nxt;
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;

  // ---------------------------------------------------------------
  // refresh timer: prescaler and interval counter
  logic [4:0]       pre_r, pre_nxt;
  logic [8:0]       ivl_r, ivl_nxt;
  logic [8:0]       ivl_cfg;
  logic             expire;
  sdadr_ref_state_t ref_st_r, ref_st_nxt;

  assign ivl_cfg = timing_r[`SDADR_REF_MSB:`SDADR_REF_LSB];

  // the counter reloads on expiry at once, independent of the pending refresh
  always_comb
  begin
    pre_nxt = pre_r;
    ivl_nxt = ivl_r;
    expire  = 1'b0;
    if (ivl_cfg == 9'h_000)
    begin
      pre_nxt = 5'h_00;
      ivl_nxt = 9'h_000;
    end
    else if (pre_r == 5'(PRESCALE - 1))
    begin
      pre_nxt = 5'h_00;
      if (ivl_r >= ivl_cfg - 9'h_001)
      begin
        ivl_nxt = 9'h_000;
        expire  = 1'b1;
      end
      else
      begin
        ivl_nxt = ivl_r + 9'h_001;
      end
    end
    else
    begin
      pre_nxt = pre_r + 5'h_01;
    end
  end

  // refresh request waits for the processor bus arbitration point
  always_comb
  begin
    ref_st_nxt = ref_st_r;
    case (ref_st_r)
      SDADR_REF_IDLE:
        if (expire)
          ref_st_nxt = SDADR_REF_PENDING;
      SDADR_REF_PENDING:
        if (arb_point_i)
          ref_st_nxt = SDADR_REF_ISSUE;
      SDADR_REF_ISSUE:
        ref_st_nxt = expire ? SDADR_REF_PENDING : SDADR_REF_IDLE;
      default:
        ref_st_nxt = SDADR_REF_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_r    <= 5'h_00;
      ivl_r    <= 9'h_000;
      ref_st_r <= SDADR_REF_IDLE;
    end
    else if (ce_i)
    begin
      pre_r    <= pre_nxt;
      ivl_r    <= ivl_nxt;
      ref_st_r <= ref_st_nxt;
    end
  end

  assign ref_pend_r = (ref_st_r == SDADR_REF_PENDING);
  assign ref_cmd_o  = (ref_st_r == SDADR_REF_ISSUE);

  // ---------------------------------------------------------------
  // array decode; lowest-numbered match wins if software overlapped arrays
  logic [NUM_ARRAYS-1:0] hits;
  sdadr_decode_t         decode_nxt;

  genvar g;
  generate
    for (g = 0; g < NUM_ARRAYS; g++)
    begin : g_match
      sdadr_match u_match (
        .cfg_i  (arr_r[g]),
        .addr_i (mem_addr_i),
        .hit_o  (hits[g])
      );
    end
  endgenerate

  always_comb
  begin
    decode_nxt = decode_r;
    if (mem_req_i)
    begin
      decode_nxt = '0;
      for (int i = NUM_ARRAYS - 1; i >= 0; i--)
      begin
        if (hits[i])
        begin
          decode_nxt.hit       = 1'b1;
          decode_nxt.array_sel = 2'(i);
          decode_nxt.mux_mode  = arr_r[i][`SDADR_MUX_MSB:`SDADR_MUX_LSB];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // parity generation and checking
  sdadr_par_pins_t par_r, par_nxt;
  logic            par_err_nxt;
  logic            par_en, par_cpu;
  logic [3:0]      gen_par, chk_par;

  assign par_en  = timing_r[`SDADR_PAR_EN_BIT];
  assign par_cpu = timing_r[`SDADR_PAR_CPU_BIT];

  // even parity per byte lane
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      gen_par[b] = ^mem_wdata_i[8*b +: 8];
      chk_par[b] = ^mem_rdata_i[8*b +: 8];
    end
    par_nxt = '0;
    if (par_en)
    begin
      par_nxt.oe  = 4'h_F;
      par_nxt.out = (mem_write_i && par_cpu) ? cpu_parity_i : gen_par;
    end
    // no drive while disabled, pins stay tristate
    par_err_nxt = par_en && rd_valid_i && (chk_par != par_in_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      par_r     <= '0;
      par_err_r <= 1'b0;
      decode_r  <= '0;
    end
    else if (ce_i)
    begin
      par_r     <= par_nxt;
      par_err_r <= par_err_nxt;
      decode_r  <= decode_nxt;
    end
  end

  assign par_pins_o = par_r;
  assign par_err_o  = par_err_r;
  assign decode_o   = decode_r;

  // ---------------------------------------------------------------
  // checks
  AST_PAR_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !par_en |=> (par_pins_o.oe == 4'h_0) && !par_err_o)
    else $error("parity pins driven while parity disabled");

  AST_PAR_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && par_en |=> par_pins_o.oe == 4'h_F)
    else $error("parity pins not driven while enabled");

  AST_PAR_CPU: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && par_en && par_cpu && mem_write_i |=> par_pins_o.out == $past(cpu_parity_i))
    else $error("processor parity not forwarded");

  AST_REF_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    (ivl_cfg == 9'h_000) [*3] |-> !ref_cmd_o)
    else $error("refresh issued with zero interval");

  AST_REF_ARB: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ref_cmd_o) |-> $past(arb_point_i))
    else $error("refresh issued outside arbitration point");

  AST_REF_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && expire |=> ivl_r == 9'h_000)
    else $error("refresh timer did not reload");

  AST_PRESCALE: assert property (@(posedge clk_i) disable iff (rst_i)
    expire |-> pre_r == 5'(PRESCALE - 1))
    else $error("expiry off prescaler boundary");

  AST_LOWEST: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mem_req_i && hits[0] |=> decode_o.hit && decode_o.array_sel == 2'd0)
    else $error("lowest array not selected");

  AST_RESET_CLR: assert property (@(posedge clk_i)
    rst_i |=> !par_en && !par_cpu && ivl_cfg == 9'h_000)
    else $error("control bits not cleared by reset");

endmodule : sdadr_top

/* File: verif/sdadr_sdram_model.sv */
/*
  sdram array model: answers a bench read request one cycle later with
  data and per-byte even parity. assumes the bench raises rd_go_i for
  one cycle per read; bad_i corrupts lane 0 on purpose.
*/
`timescale 1ns/1ps
module sdadr_sdram_model
(
  // clock and request
  input  wire logic        clk_i,
  input  wire logic        rd_go_i,
  input  wire logic        bad_i,
  input  wire logic [31:0] data_i,
  // read return
  output logic [31:0]      rdata_o = '0,
  output logic [3:0]       par_o   = '0,
  output logic             valid_o = 1'b0
);
  // released lines show the inverse so a stale value never passes
  always @(posedge clk_i)
  begin
    valid_o <= rd_go_i;
    if (rd_go_i)
    begin
      rdata_o <= data_i;
      par_o   <= {^data_i[31:24], ^data_i[23:16], ^data_i[15:8],
                  ^data_i[7:0] ^ bad_i};
    end
    else
    begin
      rdata_o <= ~rdata_o;
      par_o   <= ~par_o;
    end
  end
endmodule : sdadr_sdram_model

/* File: verif/testbench.sv */
/*
  self-checking bench of sdadr_top: registers, parity, decode, refresh.
  drives ce_i and sel_i itself; all byte lanes selected unless a test narrows them.
*/
`timescale 1ns/1ps
`include "sdadr_regs.svh"
module testbench
  import sdadr_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, ref_cmd_o;
  logic mem_req_i = 0, mem_write_i = 0, arb_point_i = 0, rd_go = 0, bad = 0;
  logic rd_valid, par_err_o, ce = 1;
  logic [11:0] adr_i = '0;
  logic [3:0]  cpu_parity_i = '0, par_in, sel = 4'hF;
  logic [27:0] mem_addr_i = '0;
  logic [31:0] dat_i = '0, mem_wdata_i = '0, dat_o, mem_rdata, q, rnd;
  logic [2:0]  sz[4], mx[4], e;
  logic [7:0]  bs[4];
  sdadr_decode_t   decode_o;
  sdadr_par_pins_t par_pins_o;
  int fail_count = 0, total_checks = 0, ref_cnt = 0, err_cnt = 0, cyc_cnt = 0, n;

  always #5 clk_i = ~clk_i;

  sdadr_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .mem_req_i(mem_req_i), .mem_write_i(mem_write_i),
    .mem_addr_i(mem_addr_i), .arb_point_i(arb_point_i), .cpu_parity_i(cpu_parity_i),
    .mem_wdata_i(mem_wdata_i), .ref_cmd_o(ref_cmd_o), .decode_o(decode_o),
    .par_pins_o(par_pins_o), .par_in_i(par_in), .mem_rdata_i(mem_rdata),
    .rd_valid_i(rd_valid), .par_err_o(par_err_o));

  sdadr_sdram_model u_mem (.clk_i(clk_i), .rd_go_i(rd_go), .bad_i(bad),
    .data_i(rnd), .rdata_o(mem_rdata), .par_o(par_in), .valid_o(rd_valid));

  task automatic results();
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // classic single cycle; waits for ack, takes data at that edge
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb

  task automatic rd(input logic b);
    @(posedge clk_i);
    {rd_go, bad} <= {1'b1, b};
    @(posedge clk_i);
    rd_go <= 0;
    repeat (3) @(posedge clk_i);
  endtask : rd

  // lowest-numbered matching array wins, hence the downward walk
  function automatic logic [2:0] exp_dec(input logic [27:0] a);
    logic [2:0] r;
    r = '0;
    for (int i = 3; i >= 0; i--)
      if (sz[i] != 0 && (a[27:20] >> (sz[i] - 1)) == (bs[i] >> (sz[i] - 1)))
        r = {1'b1, 2'(i)};
    return r;
  endfunction : exp_dec

  // pulse counters and hang guard
  always @(posedge clk_i)
  begin
    ref_cnt += (ref_cmd_o === 1'b1);
    err_cnt += (par_err_o === 1'b1);
    if (++cyc_cnt == 5000)
    begin
      fail_count++;
      results();
    end
  end

  initial
  begin
    rnd = $urandom(32'hfe04_3549);
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 5; i++)
    begin
      wb(0, (i == 4) ? 12'h100 : 12'h110 + 12'(i * 4), 0);
      chk("reset_val", 0, q);
    end
    for (int i = 0; i < 4; i++)
    begin
      rnd = $urandom;
      wb(1, 12'h110 + 12'(i * 4), rnd);
      wb(0, 12'h110 + 12'(i * 4), 0);
      chk("array_reg", rnd & `SDADR_ARRAY_WMASK, q);
    end
    wb(1, 12'h1F0, 32'hFFFF_FFFF);
    wb(0, 12'h1F0, 0);
    chk("unmapped", 0, q);
    @(posedge clk_i);
    {mem_req_i, mem_write_i, mem_wdata_i} <= {2'b11, rnd};
    rd(1);
    chk("par_oe_off", 0, par_pins_o.oe);
    chk("par_err_off", 0, err_cnt);
    wb(1, 12'h100, 32'h0000_1000);
    repeat (2) @(negedge clk_i);
    chk("par_oe_on", 4'hF, par_pins_o.oe);
    chk("par_gen", {^rnd[31:24], ^rnd[23:16], ^rnd[15:8], ^rnd[7:0]}, par_pins_o.out);
    rd(0);
    chk("par_err_good", 0, err_cnt);
    rd(1);
    chk("par_err_bad", 1, err_cnt);
    wb(1, 12'h100, 32'h0000_3000);
    cpu_parity_i <= 4'hA;
    wb(0, 12'h100, 0);
    chk("ctrl_reg", 32'h0000_3000, q);
    chk("par_cpu", 4'hA, par_pins_o.out);
    // aligned, non-overlapping layout, largest lowest; array 3 off
    {sz[0], bs[0], sz[1], bs[1], sz[2], bs[2], sz[3], bs[3]} =
      {3'd7, 8'h00, 3'd6, 8'h40, 3'd1, 8'h60, 3'd0, 8'h70};
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        mx[i] = 3'($urandom);
        wb(1, 12'h110 + 12'(i * 4), {4'h0, bs[i], 13'h0, mx[i], 1'b0, sz[i]});
      end
      for (int j = 0; j < 40; j++)
      begin
        @(posedge clk_i);
        {mem_write_i, mem_addr_i} <= {1'b0, (j == 0) ? 28'h600_0000 : 28'($urandom)};
        @(posedge clk_i);
        @(negedge clk_i);
        e = exp_dec(mem_addr_i);
        if (e[2])
          chk("decode", {e, mx[e[1:0]]}, decode_o);
        else
          chk("decode_miss", 0, decode_o.hit);
      end
      {sz[3], bs[3]} = {3'd1, 8'h60}; // overlap with array 2 on purpose
    end
    // clock enable low freezes the decode; it resumes once raised
    @(posedge clk_i);
    {ce, mem_addr_i} <= {1'b0, 28'h400_0000};
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("ce_hold", e[2], decode_o.hit);
    @(posedge clk_i);
    ce <= 1;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("decode_ce", {3'b101, mx[1]}, decode_o);
    wb(1, 12'h100, 32'h0001_0000);
    repeat (100) @(posedge clk_i);
    chk("ref_wait_arb", 0, ref_cnt);
    wb(0, 12'h104, 0);
    chk("status", 32'h0000_0003, q);
    arb_point_i <= 1;
    @(posedge clk_i);
    arb_point_i <= 0;
    repeat (3) @(posedge clk_i);
    chk("ref_merged", 1, ref_cnt);
    arb_point_i <= 1;
    repeat (640) @(posedge clk_i);
    chk("ref_rate", 1, ref_cnt >= 20 && ref_cnt <= 22);
    wb(1, 12'h100, 0);
    repeat (5) @(posedge clk_i);
    n = ref_cnt;
    repeat (200) @(posedge clk_i);
    chk("ref_off", n, ref_cnt);
    sel <= 4'h4;
    wb(1, 12'h100, 32'hFFFF_FFFF);
    sel <= 4'hF;
    wb(0, 12'h100, 0);
    chk("byte_lanes", 32'h00FF_0000, q);
    results();
  end
endmodule : testbench
